// File: src/elscr_pkg.sv
/*
 * Shared layouts, offsets and reset values of the link and slot
 * configuration register bank.
 * Assumes a 32-bit APB register bus and one 20 MHz clock domain.
 */
package elscr_pkg;

    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 32;
    localparam int          N_EV         = 3;

    // Byte offsets of the register words
    localparam logic [11:0] OFF_LINK     = 12'h0C0;
    localparam logic [11:0] OFF_SLOT_CAP = 12'h0C4;
    localparam logic [11:0] OFF_SLOT_CTL = 12'h0C8;
    localparam logic [11:0] OFF_IRQ_STAT = 12'h100;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h104;

    // Reset values
    localparam logic [1:0]  ASPM_RST     = 2'h0;
    localparam logic [3:0]  SPEED_RST    = 4'h1;
    localparam logic [5:0]  WIDTH_RST    = 6'h01;
    localparam logic        SCLK_RST     = 1'b1;
    localparam logic [7:0]  PLV_RST      = 8'h00;
    localparam logic [1:0]  PLS_RST      = 2'h0;

    // Event positions in the interrupt status word
    localparam int          EV_TRAIN_DONE = 0;
    localparam int          EV_TRAIN_ERR  = 1;
    localparam int          EV_LINK_CHG   = 2;

    typedef struct packed {
        logic [7:0] rsvd_hi;
        logic       ext_sync;
        logic       common_clk;
        logic       retrain;
        logic       link_dis;
        logic       rcb;
        logic       rsvd2;
        logic [1:0] aspm;
    } elscr_link_ctl_type;

    typedef struct packed {
        logic [2:0] rsvd;
        logic       slot_clk;
        logic       training;
        logic       train_err;
        logic [5:0] width;
        logic [3:0] speed;
    } elscr_link_stat_type;

    typedef struct packed {
        logic [12:0] slot_num;
        logic [1:0]  rsvd;
        logic [1:0]  pwr_scale;
        logic [7:0]  pwr_value;
        logic        hp_capable;
        logic        hp_surprise;
        logic        pwr_ind_pres;
        logic        att_ind_pres;
        logic        mrl_pres;
        logic        pwr_ctl_pres;
        logic        att_btn_pres;
    } elscr_slot_cap_type;

    typedef struct packed {
        logic [4:0] rsvd;
        logic       pwr_ctl;
        logic [1:0] pwr_ind;
        logic [1:0] att_ind;
        logic       hp_int_en;
        logic       cmd_cpl_en;
        logic       pres_chg_en;
        logic       mrl_chg_en;
        logic       pwr_fault_en;
        logic       att_btn_en;
    } elscr_slot_ctl_type;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } elscr_apb_req_type;

    typedef struct packed {
        logic              pready;
        logic [DATA_W-1:0] prdata;
        logic              pslverr;
    } elscr_apb_rsp_type;

    // Link state reported by the training logic
    typedef struct packed {
        logic [3:0] speed;
        logic [5:0] width;
        logic       training;
        logic       train_err;
    } elscr_link_in_type;

endpackage : elscr_pkg

// File: src/elscr_apb.sv
/*
 * APB slave handshake: one wait state, registered answer.
 * Assumes the parent decodes the address and supplies read data.
 */
`timescale 1ns/10ps
module elscr_apb (
    input  wire logic                       clock,  // Core clock
    input  wire logic                       rst,    // Sync reset
    input  wire elscr_pkg::elscr_apb_req_type req,  // Bus request
    input  wire logic [31:0]                rdata,  // Decoded read data
    input  wire logic                       hit,    // Address mapped
    output elscr_pkg::elscr_apb_rsp_type    rsp,    // Bus answer
    output logic                            wr_en   // Write commit pulse
);
    import elscr_pkg::*;

    elscr_apb_rsp_type q, d;

    always_comb begin
        d         = q;
        d.pready  = req.psel & req.penable & ~q.pready;
        d.pslverr = d.pready & ~hit;
        if (d.pready && !req.pwrite) begin
            d.prdata = hit ? rdata : '0;
        end
        if (rst) begin
            d = '0;
        end
    end

    always_ff @(posedge clock) begin
        q <= d;
    end

    assign rsp   = q;
    // Commit at the very edge that samples pready high
    assign wr_en = req.psel & req.penable & req.pwrite & q.pready & hit;

endmodule : elscr_apb

// File: src/elscr_irq.sv
/*
 * Sticky event status with write-one-to-clear, mask and level irq.
 * Assumes events are one-cycle pulses on the core clock.
 */
`timescale 1ns/10ps
module elscr_irq #(
    parameter int N = 3
) (
    input  wire logic         clock,    // Core clock
    input  wire logic         rst,      // Sync reset
    input  wire logic [N-1:0] event_in, // Event pulses
    input  wire logic         wr_stat,  // Clear write to status
    input  wire logic         wr_mask,  // Write to mask
    input  wire logic [N-1:0] wdata,    // Write data
    output logic [N-1:0]      status,   // Sticky status
    output logic [N-1:0]      mask,     // Enable mask
    output logic              irq       // Level interrupt
);
    // Status and mask each fit one bus word
    if (N < 1 || N > 32) begin : g_bad_n
        $error("elscr_irq: N out of range");
    end

    typedef struct packed {
        logic [N-1:0] st;
        logic [N-1:0] mk;
        logic         irq;
    } elscr_irq_state_type;

    elscr_irq_state_type q, d;

    always_comb begin
        d = q;
        // Set wins over a clear in the same cycle
        d.st = (q.st & ~(wr_stat ? wdata : '0)) | event_in;
        if (wr_mask) begin
            d.mk = wdata;
        end
        d.irq = |(d.st & d.mk);
        if (rst) begin
            d = '0;
        end
    end

    always_ff @(posedge clock) begin
        q <= d;
    end

    assign status = q.st;
    assign mask   = q.mk;
    assign irq    = q.irq;

endmodule : elscr_irq

// File: src/elscr_regs.sv
/*
 * Link control/status and slot capability/control register bank of a
 * reversible express bridge, reached over APB.
 * Assumes link state inputs and straps are synchronous to clock.
 */
//Behaviour
// [RL1] Link power-state control is a two-bit RW field, 00 none to 11 both, reset 00.
// [RL2] Read completion boundary bit 3 is read-only and always zero.
// [RL3] Link disable and retrain bits ignore writes in forward mode, RW in reverse, reset 0.
// [RL4] Negotiated speed reads at bits 19:16, read-only, reset 1 for 2.5 Gb/s.
// [RL5] Negotiated width reads at bits 25:20 in one-hot codes, reset 000001.
// [RL6] Hot-plug slot capability bits read one only with hot-plug on in reverse mode.
// [RL7] Those capability bits are loaded from the hot-plug strap at reset.
// [RL8] Slot control bit 4 is a RW command-completed interrupt enable, reset 0.
// [RL9] Slot control bit 5 is a RW hot-plug interrupt enable, reset 0.
// [RL10] Slot control bit 1 is a RW power-fault event enable, reset 0.
// [RL11] Slot power limit value at bits 14:7 is read-only and resets to 00h.
// [RL12] Slot power limit scale at bits 16:15 is read-only and resets to 00.
// [RL13] Slot control holds RW indicator fields 7:6, 9:8 and power control bit 10, reset 0.
`timescale 1ns/10ps
module elscr_regs (
    input  wire logic                        clock,          // 20 MHz core clock
    input  wire logic                        rst,            // Sync reset, high
    input  wire elscr_pkg::elscr_apb_req_type apb_req,       // APB request
    output elscr_pkg::elscr_apb_rsp_type     apb_rsp,        // APB answer
    input  wire elscr_pkg::elscr_link_in_type link_in,       // Trained link state
    input  wire logic                        reverse_mode,   // Reverse bridge
    input  wire logic                        hot_plug_strap, // Hot-plug strap
    output logic [1:0]                       aspm_ctrl,      // Power-state entry
    output logic                             link_disable,   // Link disable
    output logic                             link_retrain,   // Retrain request
    output logic                             common_clock,   // Common clock cfg
    output logic                             extended_sync,  // Extended sync
    output elscr_pkg::elscr_slot_ctl_type    slot_ctl,       // Slot control
    output logic                             irq             // Level interrupt
);
    import elscr_pkg::*;

    typedef struct packed {
        elscr_link_ctl_type  lctl;
        elscr_link_stat_type lstat;
        logic                hp_cap;
        elscr_slot_ctl_type  sctl;
    } elscr_state_type;

    elscr_state_type    q, d;
    elscr_slot_cap_type cap_word;
    logic [31:0]        rdata;
    logic               hit;
    logic               wr_en;
    logic [N_EV-1:0]    events;
    logic [N_EV-1:0]    irq_status;
    logic [N_EV-1:0]    irq_mask;
    elscr_apb_rsp_type  rsp;
    logic               irq_w;
    logic               link_wr;
    logic               ctl_wr;
    logic               stat_wr;
    logic               mask_wr;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == OFF_LINK) || (a == OFF_SLOT_CAP) || (a == OFF_SLOT_CTL)
                    || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK);
    endfunction : is_mapped

    function automatic logic wr_at(input logic [ADDR_W-1:0] off);
        wr_at = wr_en && (apb_req.paddr == off);
    endfunction : wr_at

    // Capability word built from the latched strap
    always_comb begin
        cap_word              = '0;
        cap_word.att_btn_pres = q.hp_cap;     // RL6
        cap_word.mrl_pres     = q.hp_cap;     // RL6
        cap_word.att_ind_pres = q.hp_cap;     // RL6
        cap_word.pwr_ind_pres = q.hp_cap;     // RL6
        cap_word.hp_capable   = q.hp_cap;     // RL6
        cap_word.pwr_value    = PLV_RST;      // RL11
        cap_word.pwr_scale    = PLS_RST;      // RL12
    end

    // Read mux; unmapped words read zero with an error answer
    always_comb begin
        rdata = '0;
        hit   = is_mapped(apb_req.paddr);
        unique case (apb_req.paddr)
            OFF_LINK:     rdata = {q.lstat, q.lctl};
            OFF_SLOT_CAP: rdata = cap_word;
            OFF_SLOT_CTL: rdata = {16'h0000, q.sctl};
            OFF_IRQ_STAT: rdata = {{(32-N_EV){1'b0}}, irq_status};
            OFF_IRQ_MASK: rdata = {{(32-N_EV){1'b0}}, irq_mask};
            default:      rdata = '0;
        endcase
    end

    // Events compare the new sample with the held one
    always_comb begin
        events                = '0;
        events[EV_TRAIN_DONE] = q.lstat.training & ~link_in.training;
        events[EV_TRAIN_ERR]  = ~q.lstat.train_err & link_in.train_err;
        events[EV_LINK_CHG]   = (q.lstat.speed != link_in.speed)
                                | (q.lstat.width != link_in.width);
    end

    always_comb begin
        d = q;
        d.lstat.speed     = link_in.speed;        // RL4
        d.lstat.width     = link_in.width;        // RL5
        d.lstat.training  = link_in.training;
        d.lstat.train_err = link_in.train_err;
        if (wr_at(OFF_LINK)) begin
            d.lctl.aspm       = apb_req.pwdata[1:0];   // RL1
            d.lctl.common_clk = apb_req.pwdata[6];
            d.lctl.ext_sync   = apb_req.pwdata[7];
            // Forward bridge leaves these two untouched
            if (reverse_mode) begin
                d.lctl.link_dis = apb_req.pwdata[4];   // RL3
                d.lctl.retrain  = apb_req.pwdata[5];   // RL3
            end
        end
        if (wr_at(OFF_SLOT_CTL)) begin
            d.sctl      = apb_req.pwdata[15:0];   // RL8 RL9 RL10 RL13
            d.sctl.rsvd = '0;
        end
        d.lctl.rcb     = 1'b0;                    // RL2
        d.lctl.rsvd2   = 1'b0;
        d.lctl.rsvd_hi = '0;
        d.lstat.rsvd   = '0;
        if (rst) begin
            d                = '0;
            d.lctl.aspm      = ASPM_RST;          // RL1
            d.lstat.speed    = SPEED_RST;         // RL4
            d.lstat.width    = WIDTH_RST;         // RL5
            d.lstat.slot_clk = SCLK_RST;
            // Strap caught while reset is held, a clocked capture
            d.hp_cap = hot_plug_strap & reverse_mode;  // RL6 RL7
        end
    end

    always_ff @(posedge clock) begin
        q <= d;
    end

    elscr_apb u_apb (
        .clock (clock),
        .rst   (rst),
        .req   (apb_req),
        .rdata (rdata),
        .hit   (hit),
        .rsp   (rsp),
        .wr_en (wr_en)
    );

    elscr_irq #(.N(N_EV)) u_irq (
        .clock    (clock),
        .rst      (rst),
        .event_in (events),
        .wr_stat  (stat_wr),
        .wr_mask  (mask_wr),
        .wdata    (apb_req.pwdata[N_EV-1:0]),
        .status   (irq_status),
        .mask     (irq_mask),
        .irq      (irq_w)
    );

    assign apb_rsp       = rsp;
    assign irq           = irq_w;
    assign aspm_ctrl     = q.lctl.aspm;
    assign link_disable  = q.lctl.link_dis;
    assign link_retrain  = q.lctl.retrain;
    assign common_clock  = q.lctl.common_clk;
    assign extended_sync = q.lctl.ext_sync;
    assign slot_ctl      = q.sctl;

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // A process follows what the function reads; a plain assign may not
    always_comb begin
        link_wr = wr_at(OFF_LINK);
        ctl_wr  = wr_at(OFF_SLOT_CTL);
        stat_wr = wr_at(OFF_IRQ_STAT);
        mask_wr = wr_at(OFF_IRQ_MASK);
    end

    a_aspm_reset: assert property ( // RL1
        $fell(rst) |-> aspm_ctrl == 2'h0)
        else $error("power-state field not zero after reset");

    a_aspm_write: assert property ( // RL1
        link_wr |=> aspm_ctrl == $past(apb_req.pwdata[1:0]))
        else $error("power-state field did not take written value");

    a_rcb_reads_zero: assert property ( // RL2
        apb_req.paddr == OFF_LINK |-> rdata[3] == 1'b0)
        else $error("completion boundary bit read as one");

    a_fwd_bits_hold: assert property ( // RL3
        link_wr && !reverse_mode |=> $stable(link_disable) && $stable(link_retrain))
        else $error("forward bridge let disable or retrain change");

    a_rev_bits_write: assert property ( // RL3
        link_wr && reverse_mode
        |=> {link_retrain, link_disable} == $past(apb_req.pwdata[5:4]))
        else $error("reverse bridge ignored disable or retrain write");

    a_speed_report: assert property ( // RL4
        ##1 (apb_req.paddr == OFF_LINK) |-> rdata[19:16] == $past(link_in.speed))
        else $error("reported speed does not follow link");

    a_width_report: assert property ( // RL5
        ##1 (apb_req.paddr == OFF_LINK) |-> rdata[25:20] == $past(link_in.width))
        else $error("reported width does not follow link");

    a_hp_cap_bits: assert property ( // RL6
        apb_req.paddr == OFF_SLOT_CAP
        |-> {rdata[6], rdata[4:2], rdata[0]} == {5{q.hp_cap}} && !rdata[1] && !rdata[5])
        else $error("hot-plug capability bits inconsistent");

    a_hp_strap_load: assert property ( // RL7
        $fell(rst) |-> q.hp_cap == $past(hot_plug_strap & reverse_mode))
        else $error("hot-plug capability not loaded from strap");

    a_slot_enables: assert property ( // RL8 RL9 RL10
        ctl_wr |=> {slot_ctl.hp_int_en, slot_ctl.cmd_cpl_en, slot_ctl.pwr_fault_en}
                   == {$past(apb_req.pwdata[5]), $past(apb_req.pwdata[4]),
                       $past(apb_req.pwdata[1])})
        else $error("slot event enables did not take write");

    a_slot_indicators: assert property ( // RL13
        ctl_wr |=> (slot_ctl[10:6] == $past(apb_req.pwdata[10:6]))
                   ##1 $stable(slot_ctl[10:6]))
        else $error("indicator controls not written or not held");

    a_power_limit: assert property ( // RL11 RL12
        apb_req.paddr == OFF_SLOT_CAP |-> rdata[16:7] == 10'h000)
        else $error("slot power limit fields not zero");

    a_apb_answer: assert property (
        apb_req.psel && !apb_req.penable ##1 apb_req.psel && apb_req.penable
        |=> apb_rsp.pready)
        else $error("answer not given one cycle into access phase");

    a_irq_level: assert property (
        irq == |(irq_status & irq_mask))
        else $error("interrupt without cause");

    c_rev_retrain: cover property (link_wr && reverse_mode && apb_req.pwdata[5]);
    c_irq_raise: cover property ($rose(irq));
    c_cap_read: cover property (apb_rsp.pready && apb_req.paddr == OFF_SLOT_CAP
                                && q.hp_cap);
    c_bad_addr: cover property (apb_rsp.pslverr);

endmodule : elscr_regs

// File: bench/elscr_link_model.sv
/*
 * Stand-in for the link training logic: drives trained link state levels.
 * Assumes the bench calls set_link; levels change just after a clock edge.
 */
`timescale 1ns/10ps
module elscr_link_model (
    input  wire logic                    clock,  // Core clock
    output elscr_pkg::elscr_link_in_type link_in // Trained link state
);
    import elscr_pkg::*;

    // Starts at the reset look of the link so no event fires at start
    initial link_in = '{speed: 4'h1, width: 6'h01, training: 1'b0, train_err: 1'b0};

    task automatic set_link(input logic [3:0] sp, input logic [5:0] wd,
                            input logic tr, input logic er);
        @(posedge clock);
        link_in <= '{speed: sp, width: wd, training: tr, train_err: er};
    endtask : set_link
endmodule : elscr_link_model

// File: bench/tb_express_link_slot_config_regs.sv
/*
 * Self-checking bench of the link and slot register bank over APB.
 * Assumes elscr_pkg, elscr_regs and elscr_link_model are compiled first.
 */
`timescale 1ns/10ps
module tb_express_link_slot_config_regs;
    import elscr_pkg::*;

    logic               clock;
    logic               rst;
    logic               reverse_mode;
    logic               hot_plug_strap;
    logic [1:0]         aspm_ctrl;
    logic               link_disable;
    logic               link_retrain;
    logic               common_clock;
    logic               extended_sync;
    logic               irq;
    elscr_apb_req_type  req;
    elscr_apb_rsp_type  rsp;
    elscr_link_in_type  link_in;
    elscr_slot_ctl_type slot_ctl;
    logic [31:0]        rd;
    logic               err;
    int                 errors;
    int                 num_checks;

    elscr_regs dut (
        .clock(clock), .rst(rst), .apb_req(req), .apb_rsp(rsp), .link_in(link_in),
        .reverse_mode(reverse_mode), .hot_plug_strap(hot_plug_strap),
        .aspm_ctrl(aspm_ctrl), .link_disable(link_disable), .link_retrain(link_retrain),
        .common_clock(common_clock), .extended_sync(extended_sync),
        .slot_ctl(slot_ctl), .irq(irq)
    );

    elscr_link_model partner (.clock(clock), .link_in(link_in));

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    // Answer taken at the rising edge that samples pready high, then released
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge clock);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clock);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (rsp.pready !== 1'b1) begin
            errors++;
            $display("unexpected %0t: no pready", $time);
            summarize();
        end
        rd          = rsp.prdata;
        err         = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "read data");
    endtask : rdchk

    task automatic do_reset(input logic strap, input logic rev);
        @(posedge clock);
        rst            <= 1'b1;
        hot_plug_strap <= strap;
        reverse_mode   <= rev;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
    endtask : do_reset

    task automatic t_reset_values();
        rdchk(OFF_LINK, 32'h1011_0000);
        rdchk(OFF_SLOT_CAP, 32'h0000_005D);
        rdchk(OFF_SLOT_CTL, 32'h0);
    endtask : t_reset_values

    // Forward mode first: disable and retrain must stay low
    task automatic t_link_ctl();
        reverse_mode <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, OFF_LINK, 32'hFFFF_FFFC | 32'(c));
            rdchk(OFF_LINK, 32'h1011_00C0 | 32'(c));
            chk({30'h0, aspm_ctrl}, 32'(c), "aspm");
            chk({30'h0, link_disable, link_retrain}, 32'h0, "fwd ctl");
            chk({30'h0, common_clock, extended_sync}, 32'h3, "clk cfg");
        end
        reverse_mode <= 1'b1;
        apb(1'b1, OFF_LINK, 32'h0000_0030);
        rdchk(OFF_LINK, 32'h1011_0030);
        chk({30'h0, link_disable, link_retrain}, 32'h3, "rev ctl");
        chk({30'h0, common_clock, extended_sync}, 32'h0, "clk cfg");
    endtask : t_link_ctl

    task automatic t_slot_ctl();
        apb(1'b1, OFF_SLOT_CTL, 32'hFFFF_FFFF);
        rdchk(OFF_SLOT_CTL, 32'h0000_07FF);
        chk({16'h0, slot_ctl}, 32'h0000_07FF, "slot out");
        apb(1'b1, OFF_SLOT_CTL, 32'h0000_0012);
        rdchk(OFF_SLOT_CTL, 32'h0000_0012);
        apb(1'b1, OFF_SLOT_CTL, 32'h0000_0020);
        rdchk(OFF_SLOT_CTL, 32'h0000_0020);
        apb(1'b1, OFF_SLOT_CTL, 32'h0000_07C0);
        rdchk(OFF_SLOT_CTL, 32'h0000_07C0);
        apb(1'b1, OFF_SLOT_CAP, 32'hFFFF_FFFF);
        rdchk(OFF_SLOT_CAP, 32'h0000_005D);
    endtask : t_slot_ctl

    task automatic t_unmapped();
        apb(1'b1, 12'h0F0, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h1, "wr slverr");
        apb(1'b0, 12'h0F0, 32'h0);
        chk({31'h0, err}, 32'h1, "rd slverr");
        chk(rd, 32'h0, "rd unmapped");
    endtask : t_unmapped

    task automatic t_status_irq();
        partner.set_link(4'h1, 6'h04, 1'b0, 1'b0);
        rdchk(OFF_LINK, 32'h1041_0030);
        rdchk(OFF_IRQ_STAT, 32'h4);
        chk({31'h0, irq}, 32'h0, "irq masked");
        apb(1'b1, OFF_IRQ_MASK, 32'h7);
        repeat (2) @(negedge clock);
        chk({31'h0, irq}, 32'h1, "irq on");
        apb(1'b1, OFF_IRQ_STAT, 32'h4);
        rdchk(OFF_IRQ_STAT, 32'h0);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        partner.set_link(4'h1, 6'h04, 1'b1, 1'b0);
        partner.set_link(4'h1, 6'h04, 1'b0, 1'b1);
        rdchk(OFF_LINK, 32'h1441_0030);
        rdchk(OFF_IRQ_STAT, 32'h3);
        chk({31'h0, irq}, 32'h1, "irq events");
        apb(1'b1, OFF_IRQ_STAT, 32'h3);
        rdchk(OFF_IRQ_STAT, 32'h0);
        partner.set_link(4'h1, 6'h01, 1'b0, 1'b0);
    endtask : t_status_irq

    // Capability bits need both the strap and reverse mode at reset
    task automatic t_strap();
        do_reset(1'b0, 1'b1);
        rdchk(OFF_SLOT_CAP, 32'h0);
        rdchk(OFF_LINK, 32'h1011_0000);
        do_reset(1'b1, 1'b0);
        rdchk(OFF_SLOT_CAP, 32'h0);
        do_reset(1'b1, 1'b1);
        rdchk(OFF_SLOT_CAP, 32'h0000_005D);
        rdchk(OFF_IRQ_MASK, 32'h0);
    endtask : t_strap

    initial begin
        errors         = 0;
        num_checks     = 0;
        rst            = 1'b1;
        reverse_mode   = 1'b1;
        hot_plug_strap = 1'b1;
        req            = '0;
        do_reset(1'b1, 1'b1);
        t_reset_values();
        t_link_ctl();
        t_slot_ctl();
        t_unmapped();
        t_status_irq();
        t_strap();
        summarize();
    end
endmodule : tb_express_link_slot_config_regs
